// >>> design/flash_cmd_pkg.sv
package flash_cmd_pkg;
  localparam int CLK_MHZ     = 200;
  localparam int NS_PER_US   = 1000;
  localparam int DEF_SLEEP_NS = 3000;
  localparam int DEF_WAKE_NS  = 3000;
  localparam int DEF_WAKEID_NS = 8000;
  localparam int DEF_RSTREC_NS = 30000;

  localparam logic [7:0] OP_SLEEP  = 8'hB9;
  localparam logic [7:0] OP_WAKE   = 8'hAB;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_MID1   = 8'h90;
  localparam logic [7:0] OP_MID2   = 8'h92;
  localparam logic [7:0] OP_MID4   = 8'h94;
  localparam logic [7:0] OP_IDENT3 = 8'h9F;

  localparam logic [5:0]  OPCODE_BITS = 6'h08;
  localparam logic [5:0]  ADDR_END    = 6'h20;
  localparam logic [5:0]  BITS_MAX    = 6'h3F;
  localparam logic [5:0]  OPC_LAST    = 6'h07;
  localparam logic [23:0] ADDR_SWAP   = 24'h00_0001;
  localparam logic [4:0]  WORD_MSB    = 5'h17;
  localparam logic [5:0]  WORD_LEN    = 6'h18;
  localparam logic [5:0]  PER_DEV     = 6'h08;
  localparam logic [5:0]  PER_PAIR    = 6'h10;
  localparam logic [5:0]  PER_IDENT   = 6'h18;
  localparam logic [2:0]  LANES_1     = 3'h1;
  localparam logic [2:0]  LANES_2     = 3'h2;
  localparam logic [2:0]  LANES_4     = 3'h4;
  localparam logic [3:0]  OE_NONE     = 4'h0;
  localparam logic [15:0] CNT_ONE     = 16'h0001;

  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_OUT    = 4'b0100,
    ST_IGNORE = 4'b1000
  } frame_state_t;

  function automatic logic [15:0] ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    if (c < 1) begin
      c = 1;
    end
    ns_to_cycles = 16'(c);
  endfunction : ns_to_cycles
endpackage : flash_cmd_pkg

// >>> design/flash_power_reset_id_commands.sv
`timescale 1ns/1ps
`default_nettype none
module flash_power_reset_id_commands
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h13, // arbitrary value
  parameter logic [7:0] TYPE_CODE   = 8'h60, // arbitrary value
  parameter logic [7:0] CAP_CODE    = 8'h14, // arbitrary value
  parameter int SLEEP_ENTRY_NS = DEF_SLEEP_NS,
  parameter int WAKE_NS        = DEF_WAKE_NS,
  parameter int WAKE_ID_NS     = DEF_WAKEID_NS,
  parameter int RESET_REC_NS   = DEF_RSTREC_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // serial pins
  input  wire logic       csN,
  input  wire logic       sclk,
  input  wire logic [3:0] ioIn,
  output logic      [3:0] ioOut,
  output logic      [3:0] ioOe,
  // internal cycle from array logic
  input  wire logic       cycleStart,
  input  wire logic       cycleDone,
  // status
  output logic            writeInProgressFlag,
  output logic            asleep,
  output logic            standby,
  output logic            commandBusy,
  output logic            volatileClear
);
  localparam logic [15:0] SLEEP_CNT  = ns_to_cycles(SLEEP_ENTRY_NS);
  localparam logic [15:0] WAKE_CNT   = ns_to_cycles(WAKE_NS);
  localparam logic [15:0] WAKEID_CNT = ns_to_cycles(WAKE_ID_NS);
  localparam logic [15:0] RSTREC_CNT = ns_to_cycles(RESET_REC_NS);

  function automatic logic [23:0] shift_in(input logic [23:0] a, input logic [3:0] io, input logic [2:0] n);
    case (n)
      LANES_2: shift_in = {a[21:0], io[1:0]};
      LANES_4: shift_in = {a[19:0], io[3:0]};
      default: shift_in = {a[22:0], io[0]};
    endcase
  endfunction : shift_in

  function automatic logic [3:0] id_lanes(input logic [23:0] w, input logic [4:0] i, input logic [2:0] n);
    id_lanes = OE_NONE;
    case (n)
      LANES_2: id_lanes = {2'h0, w[i], w[i - 5'h1]};
      LANES_4: id_lanes = {w[i], w[i - 5'h1], w[i - 5'h2], w[i - 5'h3]};
      default: id_lanes[1] = w[i];
    endcase
  endfunction : id_lanes

  function automatic logic [3:0] lane_mask(input logic [2:0] n);
    case (n)
      LANES_2: lane_mask = 4'h3;
      LANES_4: lane_mask = 4'hF;
      default: lane_mask = 4'h2;
    endcase
  endfunction : lane_mask

  logic [2:0]   csSync;
  logic [2:0]   sclkSync;
  logic [3:0]   ioS1;
  logic [3:0]   ioS2;
  frame_state_t state_q;
  logic [5:0]   bitCnt_q;
  logic [7:0]   op_q;
  logic [23:0]  addr_q;
  logic [2:0]   lanes_q;
  logic         accepted_q;
  logic [23:0]  word_q;
  logic [5:0]   period_q;
  logic [4:0]   idx_q;
  logic         armed_q;
  logic         sleepPend_q;
  logic         asleep_q;
  logic         busy_q;
  logic [15:0]  delay_q;
  logic         wip_q;
  logic         volClear_q;
  logic         standby_q;
  logic [3:0]   ioOut_q;
  logic [3:0]   ioOe_q;

  // synchronisers, third stage only for edge finding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csSync   <= 3'h7;
      sclkSync <= 3'h0;
      ioS1     <= 4'h0;
      ioS2     <= 4'h0;
    end else begin
      csSync   <= {csSync[1:0], csN};
      sclkSync <= {sclkSync[1:0], sclk};
      ioS1     <= ioIn;
      ioS2     <= ioS1;
    end
  end

  logic       csHigh;
  logic       csRise;
  logic       sclkRise;
  logic       sclkFall;
  logic       sleepish;
  logic [7:0] opNext;
  logic       opAllowed;
  logic       opLast;
  logic       exactOp;
  logic       wakeOnly;
  logic       wakeId;
  logic       sleepGo;
  logic       resetGo;
  logic [5:0] addrNext;
  assign csHigh    = csSync[1];
  assign csRise    = csSync[1] & ~csSync[2];
  assign sclkRise  = sclkSync[1] & ~sclkSync[2];
  assign sclkFall  = ~sclkSync[1] & sclkSync[2];
  assign sleepish  = sleepPend_q | asleep_q;
  assign opNext    = {op_q[6:0], ioS2[0]};
  assign opLast    = (state_q == ST_OPCODE) && sclkRise && (bitCnt_q == OPC_LAST);
  assign addrNext  = bitCnt_q + {3'h0, lanes_q};
  assign exactOp   = accepted_q && (bitCnt_q == OPCODE_BITS);
  assign opAllowed = !busy_q && (!sleepish || opNext == OP_WAKE || opNext == OP_RST_EN || opNext == OP_RST);
  // wake frame ends right after opcode
  assign wakeOnly  = csRise && exactOp && op_q == OP_WAKE && sleepish;
  assign wakeId    = csRise && accepted_q && op_q == OP_WAKE && bitCnt_q >= ADDR_END && sleepish;
  // select must rise right after bit eight
  assign sleepGo   = csRise && exactOp && op_q == OP_SLEEP && !wip_q && !sleepish;
  // reset only when armed by the previous frame
  assign resetGo   = csRise && exactOp && op_q == OP_RST && armed_q;

  // frame decoder
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_OPCODE;
      bitCnt_q   <= 6'h00;
      op_q       <= 8'h00;
      addr_q     <= 24'h00_0000;
      lanes_q    <= LANES_1;
      accepted_q <= 1'b0;
      word_q     <= 24'h00_0000;
      period_q   <= PER_DEV;
    end else if (csHigh) begin
      state_q  <= ST_OPCODE;
      bitCnt_q <= 6'h00;
      lanes_q  <= LANES_1;
    end else if (sclkRise) begin
      case (state_q)
        ST_OPCODE: begin
          op_q     <= opNext;
          bitCnt_q <= bitCnt_q + 6'h01;
          if (bitCnt_q == OPC_LAST) begin
            accepted_q <= opAllowed;
            state_q    <= ST_IGNORE;
            if (opAllowed) begin
              if (opNext == OP_IDENT3 && !wip_q) begin
                word_q   <= {MAKER_CODE, TYPE_CODE, CAP_CODE};
                period_q <= PER_IDENT;
                state_q  <= ST_OUT;
              end else if (opNext == OP_WAKE && !wip_q) begin
                state_q <= ST_ADDR;
              end else if (opNext == OP_MID1 || opNext == OP_MID2 || opNext == OP_MID4) begin
                state_q <= ST_ADDR;
                lanes_q <= (opNext == OP_MID2) ? LANES_2 : (opNext == OP_MID4) ? LANES_4 : LANES_1;
              end
            end
          end
        end
        ST_ADDR: begin
          addr_q   <= shift_in(addr_q, ioS2, lanes_q);
          bitCnt_q <= addrNext;
          if (addrNext == ADDR_END) begin
            state_q <= ST_OUT;
            if (op_q == OP_WAKE) begin
              word_q   <= {DEVICE_CODE, 16'h0000};
              period_q <= PER_DEV;
            end else begin
              period_q <= PER_PAIR;
              if (shift_in(addr_q, ioS2, lanes_q) == ADDR_SWAP) begin
                word_q <= {DEVICE_CODE, MAKER_CODE, 8'h00};
              end else begin
                word_q <= {MAKER_CODE, DEVICE_CODE, 8'h00};
              end
            end
          end
        end
        default: begin
          if (bitCnt_q != BITS_MAX) begin
            bitCnt_q <= bitCnt_q + 6'h01;
          end
        end
      endcase
    end
  end

  // output shifter on falling serial clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ioOut_q <= OE_NONE;
      ioOe_q  <= OE_NONE;
      idx_q   <= WORD_MSB;
    end else if (state_q != ST_OUT) begin
      ioOe_q <= OE_NONE;
      idx_q  <= WORD_MSB;
    end else if (sclkFall) begin
      ioOut_q <= id_lanes(word_q, idx_q, lanes_q);
      ioOe_q  <= lane_mask(lanes_q);
      if ({1'b0, idx_q} < WORD_LEN - period_q + {3'h0, lanes_q}) begin
        idx_q <= WORD_MSB;
      end else begin
        idx_q <= idx_q - {2'h0, lanes_q};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else if (csRise) begin
      armed_q <= exactOp && op_q == OP_RST_EN;
    end
  end

  // sleep and delay timing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepPend_q <= 1'b0;
      asleep_q    <= 1'b0;
      busy_q      <= 1'b0;
      delay_q     <= 16'h0000;
    end else if (resetGo) begin
      sleepPend_q <= 1'b0;
      asleep_q    <= 1'b0;
      busy_q      <= 1'b1;
      delay_q     <= RSTREC_CNT;
    end else if (wakeOnly || wakeId) begin
      sleepPend_q <= 1'b0;
      asleep_q    <= 1'b0;
      busy_q      <= 1'b1;
      delay_q     <= wakeId ? WAKEID_CNT : WAKE_CNT;
    end else if (sleepGo) begin
      sleepPend_q <= 1'b1;
      delay_q     <= SLEEP_CNT;
    end else if (sleepPend_q || busy_q) begin
      delay_q <= delay_q - CNT_ONE;
      if (delay_q == CNT_ONE) begin
        asleep_q    <= sleepPend_q;
        sleepPend_q <= 1'b0;
        busy_q      <= 1'b0;
      end
    end
  end

  // flag covers the internal cycle until cycle done, or until a software reset clears it early
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wip_q <= 1'b0;
    end else if (resetGo) begin
      wip_q <= 1'b0;
    end else if (cycleStart && !sleepish && !busy_q) begin
      wip_q <= 1'b1;
    end else if (cycleDone) begin
      wip_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      volClear_q <= 1'b0;
      standby_q  <= 1'b0;
    end else begin
      volClear_q <= resetGo;
      standby_q  <= csHigh && !wip_q && !sleepish && !busy_q;
    end
  end

  assign ioOut               = ioOut_q;
  assign ioOe                = ioOe_q;
  assign writeInProgressFlag = wip_q;
  assign asleep              = asleep_q;
  assign standby             = standby_q;
  assign commandBusy         = busy_q;
  assign volatileClear       = volClear_q;

  sleep_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(asleep_q) |-> $past(sleepPend_q) && $past(delay_q) == CNT_ONE)
    else $error("sleep entered without pending sleep command");
  sleep_frame_a: assert property (@(posedge clk) disable iff (!reset_n)
    csRise && op_q == OP_SLEEP && bitCnt_q != OPCODE_BITS && !sleepPend_q |=> !sleepPend_q)
    else $error("sleep taken from a frame of wrong length");
  sleep_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(sleepPend_q) |-> delay_q == SLEEP_CNT && !asleep_q)
    else $error("sleep entry delay not loaded");
  sleep_filter_a: assert property (@(posedge clk) disable iff (!reset_n)
    opLast && !csHigh && sleepish && opNext != OP_WAKE |=> state_q == ST_IGNORE)
    else $error("command decoded while asleep");
  wake_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
    wakeOnly && !resetGo |=> busy_q && !asleep_q && delay_q == WAKE_CNT)
    else $error("wake delay not started");
  wip_ident_a: assert property (@(posedge clk) disable iff (!reset_n)
    opLast && wip_q && opNext == OP_IDENT3 |=> state_q != ST_OUT)
    else $error("identify decoded during internal cycle");
  reset_effect_a: assert property (@(posedge clk) disable iff (!reset_n)
    resetGo |=> volClear_q && !wip_q && busy_q ##1 !volClear_q)
    else $error("reset did not clear state");
  arm_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    csRise && op_q != OP_RST_EN |=> !armed_q)
    else $error("reset enable survived another frame");
  ident_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    csRise |=> ##1 ioOe_q == OE_NONE && state_q == ST_OPCODE)
    else $error("output still driven after select rose");
endmodule : flash_power_reset_id_commands
`default_nettype wire

// >>> verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // clock
  input  wire logic       clk,
  // serial pins
  output logic            csN,
  output logic            sclk,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  logic oeSeen;

  initial begin
    csN    = 1'b1;
    sclk   = 1'b0;
    ioIn   = 4'h0;
    oeSeen = 1'b0;
  end

  // one serial period: data set while low, answer taken just before rise
  task automatic tick(input logic [3:0] d, output logic [3:0] q);
    sclk <= 1'b0;
    ioIn <= d;
    repeat (16) @(negedge clk);
    q = ioOut;
    oeSeen = oeSeen | (|ioOe);
    sclk <= 1'b1;
    repeat (16) @(negedge clk);
  endtask : tick

  // called at a falling clk edge; sclk stays low outside frames
  task automatic frame(input logic [7:0] op, input int nPre, input logic [31:0] pre, input int lanes,
                       input int nRd, output logic [47:0] rd, output logic sawOe);
    logic [3:0] q;
    logic [3:0] d;
    int         i;
    rd = '0;
    d = 4'h0;
    oeSeen = 1'b0;
    csN <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      d = {3'b000, op[i]};
      tick(d, q);
    end
    for (i = nPre; i > 0; i -= lanes) begin
      d = 4'((pre >> (i - lanes)) & ((32'h1 << lanes) - 1));
      tick(d, q);
    end
    // released lanes show the inverse of the last value; single line answers on lane one
    for (i = 0; i < nRd; i += lanes) begin
      tick(~d, q);
      rd = (rd << lanes) | 48'((lanes == 1) ? {3'b000, q[1]} : (q & 4'((1 << lanes) - 1)));
    end
    sclk <= 1'b0;
    repeat (16) @(negedge clk);
    // select rises after the last bit
    csN <= 1'b1;
    sawOe = oeSeen;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import flash_cmd_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] DEVC  = 8'hA7; // arbitrary value
  localparam logic [7:0] MTYPE = 8'h42; // arbitrary value
  localparam logic [7:0] MCAP  = 8'h15; // arbitrary value
  localparam int WAKE_T = 2000;
  localparam int WKID_T = 4000;
  localparam int LIMIT  = 80000;
  logic        clk, reset_n, csN, sclk, cycleStart, cycleDone, oe;
  logic [3:0]  ioIn, ioOut, ioOe;
  logic        write_in_progress_flag, asleep, standby, busy, vclr;
  logic [47:0] rd;
  logic [31:0] a;
  logic [7:0]  ops [3];
  int          failCount, totalChecks, cycles, vcCount, v0, n, k;

  flash_power_reset_id_commands #(
    .MAKER_CODE(MAKER), .DEVICE_CODE(DEVC), .TYPE_CODE(MTYPE), .CAP_CODE(MCAP),
    .SLEEP_ENTRY_NS(100), .WAKE_NS(WAKE_T), .WAKE_ID_NS(WKID_T), .RESET_REC_NS(4000)
  ) DUT (
    .clk(clk), .reset_n(reset_n), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .cycleStart(cycleStart), .cycleDone(cycleDone), .writeInProgressFlag(write_in_progress_flag), .asleep(asleep),
    .standby(standby), .commandBusy(busy), .volatileClear(vclr)
  );
  spi_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (vclr === 1'b1) vcCount <= vcCount + 1;
  end

  always @(negedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      $display("Error timeout expected %0d seen %0d", LIMIT, cycles);
      failCount++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {47'h0, exp}, {47'h0, got});
  endtask : chkb

  task automatic chkr(input string what, input int lo, input int hi, input int got);
    totalChecks++;
    if (got < lo || got > hi) begin
      failCount++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chkr

  function automatic logic [47:0] idPair(input logic [31:0] adr);
    logic [15:0] p;
    p = (adr[23:0] == 24'h00_0001) ? {DEVC, MAKER} : {MAKER, DEVC};
    return {16'h0000, p, p};
  endfunction : idPair

  function automatic int cyc(input int ns);
    return ns / 5;
  endfunction : cyc

  task automatic fr(input logic [7:0] op, input int nPre, input logic [31:0] pre, input int lanes,
                    input int nRd);
    host.frame(op, nPre, pre, lanes, nRd, rd, oe);
    repeat (10) @(negedge clk);
  endtask : fr

  // select held high while the delay runs
  task automatic busyLen(output int cnt);
    cnt = 0;
    while (busy === 1'b1 && cnt < 3000) begin
      @(negedge clk);
      cnt++;
    end
  endtask : busyLen

  task automatic pulse(input bit done);
    if (done) cycleDone <= 1'b1;
    else cycleStart <= 1'b1;
    @(negedge clk);
    cycleDone <= 1'b0;
    cycleStart <= 1'b0;
    repeat (6) @(negedge clk);
  endtask : pulse

  task automatic sleepNow();
    fr(OP_SLEEP, 0, 0, 1, 0);
    repeat (25) @(negedge clk);
  endtask : sleepNow

  task automatic note(input string name);
    $display("test %s done", name);
  endtask : note

  initial begin
    reset_n = 1'b0;
    cycleStart = 1'b0;
    cycleDone = 1'b0;
    failCount = 0;
    totalChecks = 0;
    cycles = 0;
    vcCount = 0;
    ops = '{OP_MID1, OP_MID2, OP_MID4};
    void'($urandom(32'h0000_d134));
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chkb("asleep", 1'b0, asleep);
    chkb("standby", 1'b1, standby);
    note("powerup");
    fr(OP_IDENT3, 0, 0, 1, 12);
    chk("ident3 cut", {36'h0, MAKER, MTYPE[7:4]}, rd);
    chkb("ioOe after select", 1'b0, |ioOe);
    chkb("standby", 1'b1, standby);
    fr(OP_IDENT3, 0, 0, 1, 48);
    chk("ident3", {MAKER, MTYPE, MCAP, MAKER, MTYPE, MCAP}, rd);
    note("identify");
    for (k = 0; k < 9; k++) begin
      a = (k < 3) ? 32'h0 : (k < 6) ? 32'h1 : ($urandom_range(0, 1) ? 32'h1 : $urandom);
      fr(ops[k % 3], 24, a, 1 << (k % 3), 32);
      chk("maker device id", idPair(a), rd);
    end
    note("maker device");
    fr(OP_WAKE, 24, $urandom, 1, 16);
    chk("device code", {32'h0, DEVC, DEVC}, rd);
    busyLen(n);
    note("device code");
    fr(OP_SLEEP, 1, 1, 1, 0);
    repeat (25) @(negedge clk);
    chkb("asleep nine bits", 1'b0, asleep);
    fr(OP_SLEEP, 0, 0, 1, 0);
    chkb("asleep early", 1'b0, asleep);
    repeat (25) @(negedge clk);
    chkb("asleep", 1'b1, asleep);
    chkb("standby asleep", 1'b0, standby);
    fr(OP_MID1, 24, 0, 1, 16);
    chkb("output asleep", 1'b0, oe);
    chkb("asleep kept", 1'b1, asleep);
    fr(OP_WAKE, 0, 0, 1, 0);
    chkb("asleep woken", 1'b0, asleep);
    chkb("busy", 1'b1, busy);
    busyLen(n);
    chkr("wake delay", cyc(WAKE_T) - 12, cyc(WAKE_T) - 2, n);
    sleepNow();
    fr(OP_WAKE, 24, $urandom, 1, 8);
    busyLen(n);
    chkr("wake id delay", cyc(WKID_T) - 12, cyc(WKID_T) - 2, n);
    note("sleep wake");
    pulse(1'b0);
    chkb("wip", 1'b1, write_in_progress_flag);
    chkb("standby wip", 1'b0, standby);
    sleepNow();
    chkb("asleep wip", 1'b0, asleep);
    fr(OP_WAKE, 24, $urandom, 1, 16);
    chkb("wake output wip", 1'b0, oe);
    fr(OP_IDENT3, 0, 0, 1, 24);
    chkb("ident3 output wip", 1'b0, oe);
    chkb("wip kept", 1'b1, write_in_progress_flag);
    pulse(1'b1);
    chkb("wip done", 1'b0, write_in_progress_flag);
    note("internal cycle");
    chkb("wip before reset", 1'b0, write_in_progress_flag);
    v0 = vcCount;
    fr(OP_RST_EN, 0, 0, 1, 0);
    fr(OP_IDENT3, 0, 0, 1, 24);
    fr(OP_RST, 0, 0, 1, 0);
    chkr("clear broken pair", v0, v0, vcCount);
    fr(OP_RST_EN, 0, 0, 1, 0);
    fr(OP_RST, 0, 0, 1, 0);
    chkr("clear pulse", v0 + 1, v0 + 1, vcCount);
    chkb("recovery busy", 1'b1, busy);
    fr(OP_IDENT3, 0, 0, 1, 8);
    chkb("output recovery", 1'b0, oe);
    busyLen(n);
    chkb("recovery over", 1'b0, busy);
    pulse(1'b0);
    fr(OP_RST_EN, 0, 0, 1, 0);
    fr(OP_RST, 0, 0, 1, 0);
    chkb("wip aborted", 1'b0, write_in_progress_flag);
    busyLen(n);
    sleepNow();
    fr(OP_RST_EN, 0, 0, 1, 0);
    fr(OP_RST, 0, 0, 1, 0);
    chkb("asleep reset", 1'b0, asleep);
    busyLen(n);
    note("software reset");
    sleepNow();
    chkb("asleep before power cycle", 1'b1, asleep);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chkb("asleep after power cycle", 1'b0, asleep);
    chkb("standby after power cycle", 1'b1, standby);
    note("power cycle");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
